// *** blank_timer.v ***
`timescale 1ns/1ns
`include "conv_regs.vh"

module blank_timer #(
	parameter CYCLES = `BLANK_CYCLES,
	parameter W      = 18
) (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire ce_i,
	input  wire start_i,
	output reg  active_o
);

	reg [W-1:0] cnt_q;

	// restart on every write, hold for the full window
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_q    <= {W{1'b0}};
			active_o <= 1'b0;
		end else if (ce_i) begin
			if (start_i) begin
				cnt_q    <= CYCLES[W-1:0] - {{(W-1){1'b0}}, 1'b1};
				active_o <= 1'b1;
			end else if (cnt_q != {W{1'b0}}) begin
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			end else begin
				active_o <= 1'b0;
			end
		end
	end

endmodule // blank_timer

// *** conv_regs.vh ***
`ifndef CONV_REGS_VH
`define CONV_REGS_VH

// register subaddresses
`define STEP_DOWN_ADDR      8'h18
`define BUCK_BOOST_ADDR     8'h19

// reset values
`define STEP_DOWN_RESET     8'h8C
`define BUCK_BOOST_RESET    8'hB2

// field layout
`define PULSE_SKIP_BIT      7
`define RESERVED_BIT        6
`define CODE_MSB            5
`define CODE_LSB            0

// step-down encoding
`define SD_BASE_MV          12'd900
`define SD_KNEE_CODE        6'h1A
`define SD_KNEE_MV          12'd1550

// buck-boost encoding
`define BB_BASE_MV          12'd1175
`define BB_KNEE_CODE        6'h0F
`define BB_KNEE_MV          12'd1550
`define BB_LAST_CODE        6'h34

// code step sizes
`define FINE_STEP_MV        12'd25
`define COARSE_STEP_MV      12'd50

// supervisor blanking
`define BLANK_TIME_US       5000
`define CLK_FREQ_MHZ        50
`define BLANK_CYCLES        (`BLANK_TIME_US * `CLK_FREQ_MHZ)

// strap settle cycles
`define STRAP_SETTLE        2'h3

`endif

// *** converter_voltage_setting_regs.v ***
// Behaviour
// - buck-boost register at 0x19, resets 0xB2
// - writes accepted only while unlocked
// - each accepted write blanks the supervisor of its own converter 5 ms
// - bit 7 pulse-skip enable, resets 1
// - pulse-skip active only under light load
// - step-down code bits 5-0, reset Ch
// - buck-boost code bits 5-0, reset 32h
// - default code follows default-select resistor
`timescale 1ns/1ns
`include "conv_regs.vh"

module converter_voltage_setting_regs #(
	parameter       BLANK_CYCLES  = `BLANK_CYCLES,
	parameter       BLANK_W       = 18,
	parameter [5:0] SD_ALT_CODE   = 6'h0C,
	parameter [5:0] BB_ALT_CODE   = 6'h32
) (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        ce_i,
	input  wire        unlock_i,
	input  wire        wr_en_i,
	input  wire [7:0]  wr_addr_i,
	input  wire [7:0]  wr_data_i,
	input  wire        rd_en_i,
	input  wire [7:0]  rd_addr_i,
	input  wire        light_load_sd_i,
	input  wire        light_load_bb_i,
	input  wire        default_select_resistor_i,
	output reg  [7:0]  rd_data_o,
	output reg         rd_valid_o,
	output reg         wr_refused_o,
	output reg  [5:0]  sd_code_o,
	output reg  [5:0]  bb_code_o,
	output reg  [11:0] sd_target_mv_o,
	output reg  [11:0] bb_target_mv_o,
	output reg         bb_code_reserved_o,
	output reg         sd_pulse_skip_o,
	output reg         bb_pulse_skip_o,
	output wire        sd_blank_o,
	output wire        bb_blank_o
);

	// reset bytes, split into fields below
	localparam [7:0] SD_RST = `STEP_DOWN_RESET;
	localparam [7:0] BB_RST = `BUCK_BOOST_RESET;

	// code field of a register byte
	function [5:0] code_of;
		input [7:0] byte_in;
		begin
			code_of = byte_in[`CODE_MSB:`CODE_LSB];
		end
	endfunction

	// register byte, reserved bit forced low
	function [7:0] pack_reg;
		input       skip;
		input [5:0] code;
		begin
			pack_reg = {skip, 1'b0, code};
		end
	endfunction

	// code to millivolts with one knee
	function [11:0] code_to_mv;
		input [5:0]  code;
		input [5:0]  knee;
		input [11:0] base;
		input [11:0] knee_mv;
		begin
			if (code <= knee)
				code_to_mv = base + `FINE_STEP_MV * {6'h00, code};
			else
				code_to_mv = knee_mv + `COARSE_STEP_MV * {6'h00, code - knee};
		end
	endfunction

	reg        sd_skip_en_q;
	reg        bb_skip_en_q;
	reg [5:0]  sd_code_q;
	reg [5:0]  bb_code_q;
	reg [2:0]  ll_sd_q;
	reg [2:0]  ll_bb_q;
	reg [2:0]  sel_q;
	reg        ll_sd_st_q;
	reg        ll_bb_st_q;
	reg [1:0]  settle_q;
	reg        strap_done_q;
	reg        sd_written_q;
	reg        bb_written_q;
	reg        sd_wr_q;
	reg        bb_wr_q;

	wire       wr_sd;
	wire       wr_bb;
	wire       wr_hit;
	wire [7:0] sd_reg;
	wire [7:0] bb_reg;

	assign wr_hit = wr_en_i && (wr_addr_i == `STEP_DOWN_ADDR || wr_addr_i == `BUCK_BOOST_ADDR);
	assign wr_sd  = wr_en_i && unlock_i && wr_addr_i == `STEP_DOWN_ADDR;
	assign wr_bb  = wr_en_i && unlock_i && wr_addr_i == `BUCK_BOOST_ADDR;

	// reserved bit held at zero
	assign sd_reg = pack_reg(sd_skip_en_q, sd_code_q);
	assign bb_reg = pack_reg(bb_skip_en_q, bb_code_q);

	// pin synchronisers, change counts when stages 2 and 3 agree
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			ll_sd_q    <= 3'h0;
			ll_bb_q    <= 3'h0;
			sel_q      <= 3'h0;
			ll_sd_st_q <= 1'b0;
			ll_bb_st_q <= 1'b0;
		end else if (ce_i) begin
			ll_sd_q <= {ll_sd_q[1:0], light_load_sd_i};
			ll_bb_q <= {ll_bb_q[1:0], light_load_bb_i};
			sel_q   <= {sel_q[1:0], default_select_resistor_i};
			if (ll_sd_q[1] == ll_sd_q[2])
				ll_sd_st_q <= ll_sd_q[2];
			if (ll_bb_q[1] == ll_bb_q[2])
				ll_bb_st_q <= ll_bb_q[2];
		end
	end

	// register storage
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			sd_skip_en_q <= SD_RST[`PULSE_SKIP_BIT];
			sd_code_q    <= code_of(SD_RST);
			bb_skip_en_q <= BB_RST[`PULSE_SKIP_BIT];
			bb_code_q    <= code_of(BB_RST);
			settle_q     <= 2'h0;
			strap_done_q <= 1'b0;
			sd_written_q <= 1'b0;
			bb_written_q <= 1'b0;
		end else if (ce_i) begin
			if (!strap_done_q) begin
				if (settle_q != `STRAP_SETTLE) begin
					settle_q <= settle_q + 2'h1;
				end else if (sel_q[1] == sel_q[2]) begin
					strap_done_q <= 1'b1;
					if (sel_q[2] && !sd_written_q && !wr_sd)
						sd_code_q <= SD_ALT_CODE;
					if (sel_q[2] && !bb_written_q && !wr_bb)
						bb_code_q <= BB_ALT_CODE;
				end
			end
			if (wr_sd) begin
				sd_skip_en_q <= wr_data_i[`PULSE_SKIP_BIT];
				sd_code_q    <= code_of(wr_data_i);
				sd_written_q <= 1'b1;
			end
			if (wr_bb) begin
				bb_skip_en_q <= wr_data_i[`PULSE_SKIP_BIT];
				bb_code_q    <= code_of(wr_data_i);
				bb_written_q <= 1'b1;
			end
		end
	end

	// read port and outputs
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_data_o          <= 8'h00;
			rd_valid_o         <= 1'b0;
			wr_refused_o       <= 1'b0;
			sd_code_o          <= 6'h00;
			bb_code_o          <= 6'h00;
			sd_target_mv_o     <= 12'h000;
			bb_target_mv_o     <= 12'h000;
			bb_code_reserved_o <= 1'b0;
			sd_pulse_skip_o    <= 1'b0;
			bb_pulse_skip_o    <= 1'b0;
			sd_wr_q            <= 1'b0;
			bb_wr_q            <= 1'b0;
		end else if (ce_i) begin
			rd_valid_o <= rd_en_i;
			if (rd_en_i) begin
				case (rd_addr_i)
					`STEP_DOWN_ADDR:  rd_data_o <= sd_reg;
					`BUCK_BOOST_ADDR: rd_data_o <= bb_reg;
					default:          rd_data_o <= 8'h00;
				endcase
			end
			wr_refused_o       <= wr_hit && !unlock_i;
			sd_wr_q            <= wr_sd;
			bb_wr_q            <= wr_bb;
			sd_code_o          <= sd_code_q;
			bb_code_o          <= bb_code_q;
			sd_target_mv_o     <= code_to_mv(sd_code_q, `SD_KNEE_CODE, `SD_BASE_MV, `SD_KNEE_MV);
			bb_target_mv_o     <= code_to_mv(bb_code_q, `BB_KNEE_CODE, `BB_BASE_MV, `BB_KNEE_MV);
			bb_code_reserved_o <= bb_code_q > `BB_LAST_CODE;
			sd_pulse_skip_o    <= sd_skip_en_q && ll_sd_st_q;
			bb_pulse_skip_o    <= bb_skip_en_q && ll_bb_st_q;
		end
	end

	blank_timer #(
		.CYCLES (BLANK_CYCLES),
		.W      (BLANK_W)
	) u_sd_blank (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.ce_i     (ce_i),
		.start_i  (sd_wr_q),
		.active_o (sd_blank_o)
	);

	blank_timer #(
		.CYCLES (BLANK_CYCLES),
		.W      (BLANK_W)
	) u_bb_blank (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.ce_i     (ce_i),
		.start_i  (bb_wr_q),
		.active_o (bb_blank_o)
	);

endmodule // converter_voltage_setting_regs

// *** converter_voltage_setting_regs_bench.sv ***
`timescale 1ns/1ns
module converter_voltage_setting_regs_bench;
	logic        clk_i, rst_n_i, ce_i, unlock_i, wr_en_i, rd_en_i, light_load_bb_i;
	logic        default_select_resistor_i, rd_valid_o, wr_refused_o, bb_code_reserved_o;
	logic        sd_pulse_skip_o, bb_pulse_skip_o, sd_blank_o, bb_blank_o;
	logic [7:0]  wr_addr_i, wr_data_i, rd_addr_i, rd_data_o;
	logic [5:0]  sd_code_o, bb_code_o;
	logic [11:0] sd_target_mv_o, bb_target_mv_o;
	wire         light_load_sd_i = light_load_bb_i;
	int          error_cnt = 0, n_tests = 0;
	logic [7:0]  ad [7] = '{8'h19, 8'h19, 8'h19, 8'h19, 8'h18, 8'h18, 8'h18};
	logic [7:0]  dv [7] = '{8'h45, 8'h0F, 8'hE3, 8'h34, 8'h00, 8'h1A, 8'h7F};
	logic [11:0] mv [7] = '{12'd1300, 12'd1550, 12'd2550, 12'd3400, 12'd900, 12'd1550, 12'd3400};
	converter_voltage_setting_regs #(.BLANK_CYCLES(20), .SD_ALT_CODE(6'h10), .BB_ALT_CODE(6'h05))
		converter_voltage_setting_regs_inst (.*);
	task chk(input string n, input logic [11:0] e, s);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clk_i);
		wr_en_i <= 1'b1;
		wr_addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_i);
		wr_en_i <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge clk_i);
		rd_en_i <= 1'b1;
		rd_addr_i <= a;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1 chk("rd_data_o", e, rd_data_o);
	endtask
	task do_reset;
		@(posedge clk_i) rst_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1;
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		#200000;
		error_cnt++;
		print_verdict;
	end
	initial begin
		{ce_i, unlock_i, wr_en_i, rd_en_i, light_load_bb_i, default_select_resistor_i} <= 6'b100000;
		{wr_addr_i, wr_data_i, rd_addr_i} <= 24'h0;
		rst_n_i <= 1'b0;
		do_reset;
		rd(8'h19, 8'hB2);
		rd(8'h18, 8'h8C);
		chk("bb_code_o", 6'h32, bb_code_o);
		chk("sd_code_o", 6'h0C, sd_code_o);
		chk("bb_target_mv_o", 12'd3300, bb_target_mv_o);
		chk("sd_target_mv_o", 12'd1200, sd_target_mv_o);
		rd(8'h1A, 8'h00);
		wr(8'h19, 8'h05);
		chk("wr_refused_o", 1'b1, wr_refused_o);
		rd(8'h19, 8'hB2);
		$display("reset and lock test done");
		@(posedge clk_i) unlock_i <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			wr(ad[i], dv[i]);
			chk("wr_refused_o", 1'b0, wr_refused_o);
			rd(ad[i], dv[i] & 8'hBF);
			chk("target_mv", mv[i], ad[i][0] ? bb_target_mv_o : sd_target_mv_o);
			chk("bb_code_reserved_o", 1'b0, bb_code_reserved_o);
		end
		@(posedge clk_i);
		#1 chk("sd_blank_o", 1'b1, sd_blank_o);
		repeat (22) @(posedge clk_i);
		#1 chk("sd_blank_o", 1'b0, sd_blank_o);
		$display("code and blanking test done");
		wr(8'h19, 8'h85);
		repeat (2) @(posedge clk_i);
		#1 chk("bb_pulse_skip_o", 1'b0, bb_pulse_skip_o);
		@(posedge clk_i) light_load_bb_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		#1 chk("bb_pulse_skip_o", 1'b1, bb_pulse_skip_o);
		chk("sd_pulse_skip_o", 1'b0, sd_pulse_skip_o);
		wr(8'h19, 8'h05);
		repeat (2) @(posedge clk_i);
		#1 chk("bb_pulse_skip_o", 1'b0, bb_pulse_skip_o);
		$display("pulse skip test done");
		@(posedge clk_i) ce_i <= 1'b0;
		wr(8'h18, 8'h81);
		@(posedge clk_i) ce_i <= 1'b1;
		rd(8'h18, 8'h3F);
		chk("sd_blank_o", 1'b0, sd_blank_o);
		$display("clock enable test done");
		@(posedge clk_i) default_select_resistor_i <= 1'b1;
		do_reset;
		repeat (8) @(posedge clk_i);
		rd(8'h18, 8'h90);
		rd(8'h19, 8'h85);
		$display("strap test done");
		print_verdict;
	end
endmodule // converter_voltage_setting_regs_bench

// *** cvsr_props.sv ***
`timescale 1ns/1ns
module cvsr_props (
	input wire        clk_i,
	input wire        rst_n_i,
	input wire        ce_i,
	input wire        unlock_i,
	input wire        wr_en_i,
	input wire [7:0]  wr_addr_i,
	input wire        rd_en_i,
	input wire        light_load_bb_i,
	input wire [7:0]  rd_data_o,
	input wire        rd_valid_o,
	input wire        wr_refused_o,
	input wire [5:0]  sd_code_o,
	input wire [5:0]  bb_code_o,
	input wire [11:0] sd_target_mv_o,
	input wire [11:0] bb_target_mv_o,
	input wire        bb_code_reserved_o,
	input wire        bb_pulse_skip_o,
	input wire        sd_blank_o,
	input wire        bb_blank_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire wr_ok = ce_i && wr_en_i && unlock_i;
	chk_read_answer: assert property (ce_i && rd_en_i |=> rd_valid_o)
		else $error("read not answered");
	chk_bit6_low: assert property (rd_valid_o |-> !rd_data_o[6])
		else $error("bit 6 read high");
	chk_locked_refuse: assert property (ce_i && wr_en_i && !unlock_i && wr_addr_i[7:1] == 7'h0C |=> wr_refused_o)
		else $error("locked write not refused");
	chk_open_take: assert property (wr_ok |=> !wr_refused_o)
		else $error("unlocked write refused");
	chk_bb_blank: assert property (wr_ok && wr_addr_i == 8'h19 |-> ##2 bb_blank_o)
		else $error("bb blanking missing");
	chk_sd_blank: assert property (wr_ok && wr_addr_i == 8'h18 |-> ##2 sd_blank_o)
		else $error("sd blanking missing");
	chk_bb_fine_mv: assert property (bb_target_mv_o != 12'h000 && bb_code_o <= 6'h0F
		|-> bb_target_mv_o == 12'd1175 + 12'd25 * bb_code_o) else $error("bb fine step wrong");
	chk_sd_coarse_mv: assert property (sd_target_mv_o != 12'h000 && sd_code_o > 6'h1A
		|-> sd_target_mv_o == 12'd1550 + 12'd50 * (sd_code_o - 6'h1A)) else $error("sd coarse step wrong");
	chk_skip_idle: assert property ((ce_i && !light_load_bb_i) [*6] |-> !bb_pulse_skip_o)
		else $error("pulse skip without light load");
	chk_reserved_flag: assert property (bb_code_reserved_o == (bb_code_o > 6'h34))
		else $error("reserved code flag wrong");
	cover property (wr_ok && wr_addr_i == 8'h19);
	cover property (wr_refused_o);
	cover property (bb_pulse_skip_o);
endmodule // cvsr_props
bind converter_voltage_setting_regs cvsr_props cvsr_props_inst (
	.clk_i              (clk_i),
	.rst_n_i            (rst_n_i),
	.ce_i               (ce_i),
	.unlock_i           (unlock_i),
	.wr_en_i            (wr_en_i),
	.wr_addr_i          (wr_addr_i),
	.rd_en_i            (rd_en_i),
	.light_load_bb_i    (light_load_bb_i),
	.rd_data_o          (rd_data_o),
	.rd_valid_o         (rd_valid_o),
	.wr_refused_o       (wr_refused_o),
	.sd_code_o          (sd_code_o),
	.bb_code_o          (bb_code_o),
	.sd_target_mv_o     (sd_target_mv_o),
	.bb_target_mv_o     (bb_target_mv_o),
	.bb_code_reserved_o (bb_code_reserved_o),
	.bb_pulse_skip_o    (bb_pulse_skip_o),
	.sd_blank_o         (sd_blank_o),
	.bb_blank_o         (bb_blank_o)
);
